/* File: logic/cal_seq_map.svh */
// Constants for the calibration sequencer: bit positions and timing.
`ifndef CAL_SEQ_MAP_SVH
`define CAL_SEQ_MAP_SVH
`define CAL_ITEMS 9
`define CAL_BIT_STROBE_OSC 0
`define CAL_BIT_TX_IF_OSC 1
`define CAL_BIT_FM_DET_RX_IF 2
`define CAL_BIT_RX_ADC 3
`define CAL_BIT_WAKE_DEMOD_OSC 4
`define CAL_BIT_LNA_FREQ 5
`define CAL_BIT_XO_TUNE 6
`define CAL_BIT_TX_ANTENNA 7
`define CAL_BIT_RX_ANTENNA 8
`define CAL_SELECT_FIRST_RESET 9'h00F
`define CAL_SELECT_SECOND_RESET 9'h000
`define CAL_STARTUP_SET 9'h00F
`define CAL_LIMIT_MS 10
`define CAL_CLOCK_KHZ 100000
`define CAL_LIMIT_CYCLES (`CAL_LIMIT_MS * `CAL_CLOCK_KHZ)
`define CAL_STEP_CYCLES_DEFAULT 1000
`endif

/* File: logic/cal_seq_pkg.sv */
// Types shared by the calibration sequencer.
`default_nettype none
package cal_seq_pkg;
  typedef logic [8:0] cal_mask_type;
  typedef struct packed {
    logic write;
    logic [1:0] target;
    logic [8:0] data;
  } reg_access_type;
  typedef struct packed {
    logic busy;
    cal_mask_type done;
    cal_mask_type active;
  } cal_status_type;
endpackage
`default_nettype wire

/* File: logic/cal_step_unit.sv */
// One calibration step engine: runs a single item for a fixed time.
`timescale 1ns/1ps
`default_nettype none
module cal_step_unit #(
  parameter int STEP_CYCLES = 1000
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic start_i,
  output logic done_o
);
  logic [31:0] count;
  logic running;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      running <= 1'b0;
      count <= 32'h0;
    end else if (start_i && !running) begin
      running <= 1'b1;
      count <= 32'h0;
    end else if (running) begin
      if (count == 32'(STEP_CYCLES - 1)) begin
        running <= 1'b0;
      end
      count <= count + 32'h1;
    end
  end

  assign done_o = running && (count == 32'(STEP_CYCLES - 1));
endmodule
`default_nettype wire

/* File: logic/calibration_sequencer.sv */
// Calibration sequencer with selection registers and input pin status.
//
// Notes on behaviour
// - One control-bit write starts selected runs, under 10ms.
// - Startup calibrates strobe, TX IF, FM/RX IF, ADC.
// - Fast startup skips the four startup calibrations.
// - Power-up and wake-up run first-selection items.
// - Initiation runs exactly the picked calibrations.
// - Optional items run on initiation, or at startup when first-selected.
// - Registers reachable locally and by remote messages.
// - Three input pin levels readable as register.
// - Remote message carries register address and data.
`timescale 1ns/1ps
`include "cal_seq_map.svh"
`default_nettype none
module calibration_sequencer #(
  parameter int STEP_CYCLES = `CAL_STEP_CYCLES_DEFAULT
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic power_up_i,
  input wire logic wake_up_i,
  input wire logic fast_startup_i,
  input wire cal_seq_pkg::reg_access_type local_access_i,
  input wire logic local_valid_i,
  input wire cal_seq_pkg::reg_access_type remote_register_message_i,
  input wire logic remote_valid_i,
  input wire logic prog_input_0_i,
  input wire logic prog_input_1_i,
  input wire logic prog_input_2_i,
  output logic [8:0] read_data_o,
  output cal_seq_pkg::cal_status_type status_o,
  output logic [2:0] prog_inputs_o
);
  import cal_seq_pkg::*;

  // Target codes of the register access.
  localparam logic [1:0] TARGET_SELECT_FIRST = 2'h0;
  localparam logic [1:0] TARGET_SELECT_SECOND = 2'h1;
  localparam logic [1:0] TARGET_CONTROL = 2'h2;
  localparam logic [1:0] TARGET_PINS = 2'h3;
  // A selected item costs its step plus two cycles of picking and handing
  // over, and the final pick adds one; this bound keeps a run of all nine
  // items inside the limit.
  localparam int MAX_STEP = (`CAL_LIMIT_CYCLES / `CAL_ITEMS) - 3;

  typedef enum logic [1:0] {IDLE, PICK, RUN} state_type;

  state_type state;
  cal_mask_type cal_select_first;
  cal_mask_type cal_select_second;
  cal_mask_type pending;
  cal_mask_type done_mask;
  logic [3:0] item;
  logic start_pulse;
  logic step_done;
  logic busy;
  reg_access_type acc;
  logic acc_valid;
  logic [2:0] pin_s1, pin_s2, pin_s3, pins;
  logic startup_req;
  logic [8:0] next_read;
  logic start_write;
  cal_mask_type startup_mask;
  cal_mask_type request_mask;

  // Remote messages take priority; a local access in the same cycle is
  // dropped, which callers avoid by polling.
  always_comb begin
    acc = remote_valid_i ? remote_register_message_i
        : local_access_i;
    acc_valid = remote_valid_i | local_valid_i;
  end

  assign startup_req = power_up_i | wake_up_i;

  // The two run masks are formed apart from the sequencer, so that the
  // fast-startup exception sits in one place. With fast startup the four
  // built-in items are dropped even when the first selection holds them.
  always_comb begin
    start_write = acc_valid && acc.write && (acc.target == TARGET_CONTROL)
                  && acc.data[0];
    if (fast_startup_i) begin
      startup_mask = cal_select_first & ~`CAL_STARTUP_SET;
    end else begin
      startup_mask = cal_select_first | `CAL_STARTUP_SET;
    end
    request_mask = cal_select_first | cal_select_second;
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cal_select_first <= `CAL_SELECT_FIRST_RESET;
      cal_select_second <= `CAL_SELECT_SECOND_RESET;
    end else if (acc_valid && acc.write) begin
      if (acc.target == TARGET_SELECT_FIRST) begin
        cal_select_first <= acc.data;
      end
      if (acc.target == TARGET_SELECT_SECOND) begin
        cal_select_second <= acc.data;
      end
    end
  end

  // Input pins pass three flops; a change counts once stages two and three
  // agree, so a glitch of one cycle never reaches the register.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pin_s1 <= 3'h0;
      pin_s2 <= 3'h0;
      pin_s3 <= 3'h0;
      pins <= 3'h0;
    end else begin
      pin_s1 <= {prog_input_2_i, prog_input_1_i, prog_input_0_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      if (pin_s2 == pin_s3) begin
        pins <= pin_s3;
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= IDLE;
      pending <= '0;
      done_mask <= '0;
      item <= 4'h0;
      start_pulse <= 1'b0;
    end else begin
      start_pulse <= 1'b0;
      case (state)
        IDLE: begin
          // Requests are taken here only; during a run they are dropped.
          if (startup_req) begin
            pending <= startup_mask;
            done_mask <= '0;
            item <= 4'h0;
            state <= PICK;
          end else if (start_write) begin
            pending <= request_mask;
            done_mask <= '0;
            item <= 4'h0;
            state <= PICK;
          end
        end
        PICK: begin
          if (item == 4'(`CAL_ITEMS)) begin
            state <= IDLE;
          end else if (pending[item]) begin
            start_pulse <= 1'b1;
            state <= RUN;
          end else begin
            item <= item + 4'h1;
          end
        end
        RUN: begin
          if (step_done) begin
            done_mask[item] <= 1'b1;
            pending[item] <= 1'b0;
            item <= item + 4'h1;
            state <= PICK;
          end
        end
        default: state <= IDLE;
      endcase
    end
  end

  // Busy is read back as the initiation bit, so software sees it set until
  // the final pick has passed and can poll for the end of a run.
  assign busy = (state != IDLE);

  // An oversized step is clipped rather than refused, so the limit holds at
  // the cost of a shorter trim per item.
  cal_step_unit #(
    .STEP_CYCLES((STEP_CYCLES < MAX_STEP) ? STEP_CYCLES : MAX_STEP)
  ) u_step (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .start_i(start_pulse),
    .done_o(step_done)
  );

  // Target three is read only: no write decode above ever matches it.
  always_comb begin
    case (acc.target)
      TARGET_SELECT_FIRST: next_read = cal_select_first;
      TARGET_SELECT_SECOND: next_read = cal_select_second;
      TARGET_CONTROL: next_read = {8'h00, busy};
      TARGET_PINS: next_read = {6'h00, pins};
      default: next_read = 9'h000;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      read_data_o <= 9'h000;
    end else if (acc_valid && !acc.write) begin
      read_data_o <= next_read;
    end
  end

  // Status lags the sequencer by one cycle; a poll of busy therefore sees
  // the end of a run one cycle late, which only lengthens the poll.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      status_o <= '0;
    end else begin
      status_o <= '{busy: busy, done: done_mask, active: pending};
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      prog_inputs_o <= 3'h0;
    end else begin
      prog_inputs_o <= pins;
    end
  end
endmodule
`default_nettype wire

/* File: verif/calibration_sequencer_properties.sv */
// Port checker for the calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module cal_seq_checker #(parameter int STEP_CYCLES = 1000) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic power_up_i,
  input wire logic wake_up_i,
  input wire logic fast_startup_i,
  input wire cal_seq_pkg::reg_access_type local_access_i,
  input wire logic local_valid_i,
  input wire cal_seq_pkg::reg_access_type remote_register_message_i,
  input wire logic remote_valid_i,
  input wire logic prog_input_0_i,
  input wire logic prog_input_1_i,
  input wire logic prog_input_2_i,
  input wire logic [8:0] read_data_o,
  input wire cal_seq_pkg::cal_status_type status_o,
  input wire logic [2:0] prog_inputs_o
);
  import cal_seq_pkg::*;
  // Longest run: nine items of step plus two cycles each, and a final pick.
  localparam int RUN_MAX = 9 * (STEP_CYCLES + 2) + 1;
  wire logic ev = local_valid_i | remote_valid_i;
  // The remote port wins a same-cycle collision, so model that choice.
  wire reg_access_type ea = remote_valid_i ? remote_register_message_i
    : local_access_i;
  wire logic go = power_up_i | wake_up_i
    | (ev & ea.write & ea.target == 2'h2 & ea.data[0]);
  wire logic [2:0] pins = {prog_input_2_i, prog_input_1_i, prog_input_0_i};
  // Runs may be far longer than a delay range can span, so count them.
  int unsigned busy_cycles;
  always_ff @(posedge clock_i) begin
    if (reset_i || !status_o.busy) begin
      busy_cycles <= 0;
    end else begin
      busy_cycles <= busy_cycles + 1;
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence wr0; ev && ea.write && ea.target == 2'h0; endsequence
  sequence rd0; ev && !ea.write && ea.target == 2'h0; endsequence
  AST_GO_BUSY: assert property (
    go && !fast_startup_i && !status_o.busy |-> ##2 status_o.busy)
    else $error("run did not start");
  AST_RUN_BOUND: assert property (
    status_o.busy |-> busy_cycles < RUN_MAX) else $error("run too long");
  AST_RUN_MIN: assert property (
    $rose(status_o.busy) |-> status_o.busy[*8]) else $error("run too short");
  AST_NO_SELF_START: assert property (
    $rose(status_o.busy) |-> $past(go, 2)) else $error("run without cause");
  AST_BUSY_READ: assert property (
    ev && !ea.write && ea.target == 2'h2 |=> read_data_o[0] == status_o.busy)
    else $error("busy bit wrong");
  AST_READBACK: assert property (
    wr0 ##1 !ev ##1 rd0 |=> read_data_o == $past(ea.data, 3))
    else $error("readback wrong");
  AST_READ_HOLD: assert property (
    !(ev && !ea.write) |=> $stable(read_data_o)) else $error("data moved");
  AST_PINS: assert property (
    (!reset_i && $stable(pins))[*6] |-> prog_inputs_o == pins)
    else $error("pin level wrong");
endmodule
bind calibration_sequencer cal_seq_checker #(.STEP_CYCLES(STEP_CYCLES))
  cal_seq_checker_inst (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .power_up_i(power_up_i),
    .wake_up_i(wake_up_i),
    .fast_startup_i(fast_startup_i),
    .local_access_i(local_access_i),
    .local_valid_i(local_valid_i),
    .remote_register_message_i(remote_register_message_i),
    .remote_valid_i(remote_valid_i),
    .prog_input_0_i(prog_input_0_i),
    .prog_input_1_i(prog_input_1_i),
    .prog_input_2_i(prog_input_2_i),
    .read_data_o(read_data_o),
    .status_o(status_o),
    .prog_inputs_o(prog_inputs_o)
  );
`default_nettype wire

/* File: verif/reg_port_model.sv */
// Register-port master standing for the host or a remote transceiver.
`timescale 1ns/1ps
`default_nettype none
module reg_port_model (
  input wire logic clock_i,
  output var cal_seq_pkg::reg_access_type access_o,
  output var logic valid_o
);
  import cal_seq_pkg::*;
  initial begin
    access_o = '0;
    valid_o = 1'b0;
  end
  // Data is inverted on release so that stale fields are never trusted.
  task automatic xfer(input logic w, input logic [1:0] t, input logic [8:0] d);
    @(posedge clock_i);
    access_o <= '{w, t, d};
    valid_o <= 1'b1;
    @(posedge clock_i);
    access_o <= '{w, t, ~d};
    valid_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
// Self-checking bench for the calibration sequencer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cal_seq_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic power_up_i = 1'b0;
  logic wake_up_i = 1'b0;
  logic fast_startup_i = 1'b0;
  logic prog_input_0_i = 1'b0;
  logic prog_input_1_i = 1'b0;
  logic prog_input_2_i = 1'b0;
  reg_access_type local_access_i, remote_register_message_i;
  logic local_valid_i, remote_valid_i;
  logic [8:0] read_data_o;
  cal_status_type status_o;
  logic [2:0] prog_inputs_o;
  int err_total = 0;
  int n_compared = 0;
  int sel1 = 'h00F;
  int sel2 = 0;
  always #5 clock_i = ~clock_i;
  reg_port_model local_port (.clock_i(clock_i),
    .access_o(local_access_i), .valid_o(local_valid_i));
  reg_port_model remote_port (.clock_i(clock_i),
    .access_o(remote_register_message_i), .valid_o(remote_valid_i));
  calibration_sequencer #(.STEP_CYCLES(4)) calibration_sequencer_inst (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .power_up_i(power_up_i),
    .wake_up_i(wake_up_i),
    .fast_startup_i(fast_startup_i),
    .local_access_i(local_access_i),
    .local_valid_i(local_valid_i),
    .remote_register_message_i(remote_register_message_i),
    .remote_valid_i(remote_valid_i),
    .prog_input_0_i(prog_input_0_i),
    .prog_input_1_i(prog_input_1_i),
    .prog_input_2_i(prog_input_2_i),
    .read_data_o(read_data_o),
    .status_o(status_o),
    .prog_inputs_o(prog_inputs_o)
  );
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input bit rem, input logic w, input logic [1:0] t,
      input logic [8:0] d);
    if (rem) remote_port.xfer(w, t, d);
    else local_port.xfer(w, t, d);
    #1;
  endtask
  task automatic pulse(input bit wake, input bit fast);
    @(posedge clock_i);
    fast_startup_i <= fast;
    if (wake) wake_up_i <= 1'b1;
    else power_up_i <= 1'b1;
    @(posedge clock_i);
    wake_up_i <= 1'b0;
    power_up_i <= 1'b0;
    #1;
  endtask
  task automatic run_end(input int exp);
    int n = 0;
    repeat (3) @(posedge clock_i);
    #1;
    chk({8'h00, status_o.busy}, 9'h001);
    while (status_o.busy !== 1'b0 && n < 200) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    if (n >= 200) begin
      err_total++;
      $display("CHECK FAILED t=%0t run still busy got=%h exp=%h", $time,
        status_o.busy, 1'b0);
    end
    chk(status_o.done, exp[8:0]);
    chk(status_o.active, 9'h000);
  endtask
  task automatic results;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    results();
  end
  initial begin
    void'($urandom(32'h6b62));
    repeat (20) @(posedge clock_i);
    reset_i <= 1'b0;
    pulse(0, 0);
    run_end(sel1 | 'h00F);
    $display("startup test done");
    for (int i = 0; i < 4; i++) begin
      sel1 = $urandom & 'h1FF;
      sel2 = $urandom & 'h1FF;
      // The first selection goes last, so its read-back follows one idle
      // cycle after the write.
      acc(!i[0], 1, 1, sel2[8:0]);
      acc(i[0], 1, 0, sel1[8:0]);
      acc(i[0], 0, 0, 0);
      chk(read_data_o, sel1[8:0]);
      acc(i[0], 1, 2, 1);
      acc(0, 0, 2, 0);
      chk(read_data_o, 1);
      run_end(sel1 | sel2);
      pulse(i[0], i[1]);
      run_end(i[1] ? sel1 & 'h1F0 : sel1 | 'h00F);
      @(posedge clock_i);
      {prog_input_2_i, prog_input_1_i, prog_input_0_i} <= 3'($urandom);
      repeat (6) @(posedge clock_i);
      acc(1, 0, 3, 0);
      chk(read_data_o, {6'h00, prog_input_2_i, prog_input_1_i,
        prog_input_0_i});
      chk({6'h00, prog_inputs_o}, {6'h00, prog_input_2_i, prog_input_1_i,
        prog_input_0_i});
      $display("request test %0d done", i);
    end
    results();
  end
endmodule
`default_nettype wire
